// [rtl/wfx_decide.sv]
// wfx_decide: combinational wake qualification for one packet
`default_nettype none
module wfx_decide (
   // packet match inputs
   input wire logic magic_hit_in,
   input wire logic direct_hit_in,
   input wire logic mng_hit_in,
   // control
   input wire logic magic_en_in,
   input wire logic direct_en_in,
   input wire logic mng_en_in,
   input wire logic excl_in,
   // results
   output logic wake_out,
   output logic excl_out
);
   logic filt_hit; // wakeup filter matched
   logic excluded; // packet kept from wake logic
   // ==========================================
   // decision
   always_comb begin
      filt_hit = (magic_hit_in & magic_en_in) |
                 (direct_hit_in & direct_en_in);
      // exclusion only with manageability on
      excluded = mng_en_in & excl_in & mng_hit_in;
      // broadcast passes mng filter so it is excluded too
      wake_out = filt_hit & ~excluded;
      excl_out = filt_hit & excluded;
   end
endmodule
`default_nettype wire

// [rtl/wfx_pkg.sv]
// wfx_pkg: constants shared by the wakeup exclusion block
`default_nettype none
package wfx_pkg;
   // ==========================================
   // register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00; // control
   localparam logic [7:0] ADDR_STAT = 8'h04; // sticky event status
   localparam logic [7:0] ADDR_MASK = 8'h08; // interrupt mask
   localparam logic [7:0] ADDR_CNT = 8'h0c; // wake counter
   // ==========================================
   // control field positions
   localparam int CTRL_EXCL_BIT = 0; // mgmt_wake_exclude
   localparam int CTRL_MNGEN_BIT = 1; // manageability enabled
   localparam int CTRL_MAGIC_BIT = 2; // magic filter enable
   localparam int CTRL_DIRECT_BIT = 3; // directed exact enable
   // reset values
   localparam logic [3:0] CTRL_RST = 4'h0; // exclusion resets to 0b
   localparam logic [1:0] STAT_RST = 2'h0;
   localparam logic [1:0] MASK_RST = 2'h0;
   // status bits
   localparam int ST_WAKE_BIT = 0; // wake issued
   localparam int ST_EXCL_BIT = 1; // match suppressed
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// [rtl/wfx_top.sv]
// wfx_top: wakeup qualification with management exclusion and AXI4-Lite
//
// The AXI4-Lite register port and the register offsets were left to the implementer.
`default_nettype none
module wfx_top (
   // clock and reset
   input wire logic CLK_IN,
   input wire logic RST_N_IN,
   // packet result from receive path, one-cycle strobe
   input wire logic PKT_VALID_IN,
   input wire logic PKT_MAGIC_IN,
   input wire logic PKT_DIRECT_IN,
   input wire logic PKT_MNG_IN,
   // wake and interrupt
   output logic WAKE_OUT,
   output logic IRQ_OUT,
   // axi4-lite write address
   input wire logic S_AXI_AWVALID_IN,
   output logic S_AXI_AWREADY_OUT,
   input wire logic [7:0] S_AXI_AWADDR_IN,
   // axi4-lite write data
   input wire logic S_AXI_WVALID_IN,
   output logic S_AXI_WREADY_OUT,
   input wire logic [31:0] S_AXI_WDATA_IN,
   input wire logic [3:0] S_AXI_WSTRB_IN,
   // axi4-lite write response
   output logic S_AXI_BVALID_OUT,
   input wire logic S_AXI_BREADY_IN,
   output logic [1:0] S_AXI_BRESP_OUT,
   // axi4-lite read address
   input wire logic S_AXI_ARVALID_IN,
   output logic S_AXI_ARREADY_OUT,
   input wire logic [7:0] S_AXI_ARADDR_IN,
   // axi4-lite read data
   output logic S_AXI_RVALID_OUT,
   input wire logic S_AXI_RREADY_IN,
   output logic [31:0] S_AXI_RDATA_OUT,
   output logic [1:0] S_AXI_RRESP_OUT
);
   // ==========================================
   // state
   typedef struct packed {
      logic [3:0] ctrl; // control bits
      logic [1:0] stat; // sticky status
      logic [1:0] mask; // interrupt mask
      logic [15:0] cnt; // wakes issued
      logic wake; // wake pulse
      logic irq; // interrupt level
      logic aw_got; // write address held
      logic [7:0] aw_addr;
      logic w_got; // write data held
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic aw_rdy; // awready, registered inverse of aw_got
      logic w_rdy; // wready, registered inverse of w_got
      logic ar_rdy; // arready, low while read data waits
   } wfx_state_s;

   wfx_state_s st_r; // registered state
   wfx_state_s st_nxt; // next state
   logic dec_wake; // decision: wake
   logic dec_excl; // decision: suppressed match

   // ==========================================
   // decision logic
   wfx_decide u_decide (
      .magic_hit_in(PKT_MAGIC_IN),
      .direct_hit_in(PKT_DIRECT_IN),
      .mng_hit_in(PKT_MNG_IN),
      .magic_en_in(st_r.ctrl[wfx_pkg::CTRL_MAGIC_BIT]),
      .direct_en_in(st_r.ctrl[wfx_pkg::CTRL_DIRECT_BIT]),
      .mng_en_in(st_r.ctrl[wfx_pkg::CTRL_MNGEN_BIT]),
      .excl_in(st_r.ctrl[wfx_pkg::CTRL_EXCL_BIT]),
      .wake_out(dec_wake),
      .excl_out(dec_excl)
   );

   // read mux for a register address
   function automatic logic [31:0] rd_mux(input logic [7:0] a,
                                          input wfx_state_s s);
      logic [31:0] v;
      v = 32'h0;
      unique case (a)
         wfx_pkg::ADDR_CTRL: v = {28'h0, s.ctrl};
         wfx_pkg::ADDR_STAT: v = {30'h0, s.stat};
         wfx_pkg::ADDR_MASK: v = {30'h0, s.mask};
         wfx_pkg::ADDR_CNT: v = {16'h0, s.cnt};
         default: v = 32'h0;
      endcase
      return v;
   endfunction

   // address is mapped
   function automatic logic is_mapped(input logic [7:0] a);
      return (a == wfx_pkg::ADDR_CTRL) || (a == wfx_pkg::ADDR_STAT) ||
             (a == wfx_pkg::ADDR_MASK) || (a == wfx_pkg::ADDR_CNT);
   endfunction

   // ==========================================
   // next state
   always_comb begin
      logic [1:0] set_bits;
      logic [1:0] clr_bits;
      logic do_wr;
      set_bits = 2'h0;
      clr_bits = 2'h0;
      do_wr = 1'b0;
      st_nxt = st_r;
      // packet evaluation on strobe
      st_nxt.wake = PKT_VALID_IN & dec_wake;
      if (PKT_VALID_IN & dec_wake) begin
         st_nxt.cnt = st_r.cnt + 16'h1;
      end
      set_bits[wfx_pkg::ST_WAKE_BIT] = PKT_VALID_IN & dec_wake;
      set_bits[wfx_pkg::ST_EXCL_BIT] = PKT_VALID_IN & dec_excl;
      // write channels captured independently
      if (S_AXI_AWVALID_IN & ~st_r.aw_got) begin
         st_nxt.aw_got = 1'b1;
         st_nxt.aw_addr = S_AXI_AWADDR_IN;
      end
      if (S_AXI_WVALID_IN & ~st_r.w_got) begin
         st_nxt.w_got = 1'b1;
         st_nxt.w_data = S_AXI_WDATA_IN;
         st_nxt.w_strb = S_AXI_WSTRB_IN;
      end
      // perform write once both held and response free
      if (st_r.aw_got & st_r.w_got & ~st_r.bvalid) begin
         do_wr = 1'b1;
         st_nxt.aw_got = 1'b0;
         st_nxt.w_got = 1'b0;
         st_nxt.bvalid = 1'b1;
         st_nxt.bresp = is_mapped(st_r.aw_addr) ? wfx_pkg::RESP_OKAY
                                                : wfx_pkg::RESP_SLVERR;
      end
      if (do_wr & st_r.w_strb[0]) begin
         unique case (st_r.aw_addr)
            wfx_pkg::ADDR_CTRL: st_nxt.ctrl = st_r.w_data[3:0];
            wfx_pkg::ADDR_STAT: clr_bits = st_r.w_data[1:0];
            wfx_pkg::ADDR_MASK: st_nxt.mask = st_r.w_data[1:0];
            default: st_nxt.ctrl = st_r.ctrl;
         endcase
      end
      // set wins over write-one-to-clear
      st_nxt.stat = (st_r.stat & ~clr_bits) | set_bits;
      st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
      if (st_r.bvalid & S_AXI_BREADY_IN) begin
         st_nxt.bvalid = 1'b0;
      end
      // read channel
      if (S_AXI_ARVALID_IN & ~st_r.rvalid) begin
         st_nxt.rvalid = 1'b1;
         st_nxt.rdata = rd_mux(S_AXI_ARADDR_IN, st_r);
         st_nxt.rresp = is_mapped(S_AXI_ARADDR_IN) ? wfx_pkg::RESP_OKAY
                                                   : wfx_pkg::RESP_SLVERR;
      end else if (st_r.rvalid & S_AXI_RREADY_IN) begin
         st_nxt.rvalid = 1'b0;
      end
      // readies come from flops so no output passes an inverter
      st_nxt.aw_rdy = ~st_nxt.aw_got;
      st_nxt.w_rdy = ~st_nxt.w_got;
      st_nxt.ar_rdy = ~st_nxt.rvalid;
   end

   // ==========================================
   // state register
   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         st_r <= '0;
         st_r.ctrl <= wfx_pkg::CTRL_RST;
         st_r.stat <= wfx_pkg::STAT_RST;
         st_r.mask <= wfx_pkg::MASK_RST;
         // channels stay ready to accept while in reset
         st_r.aw_rdy <= 1'b1;
         st_r.w_rdy <= 1'b1;
         st_r.ar_rdy <= 1'b1;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================
   // outputs straight from flops
   always_comb begin
      WAKE_OUT = st_r.wake;
      IRQ_OUT = st_r.irq;
      S_AXI_AWREADY_OUT = st_r.aw_rdy;
      S_AXI_WREADY_OUT = st_r.w_rdy;
      S_AXI_BVALID_OUT = st_r.bvalid;
      S_AXI_BRESP_OUT = st_r.bresp;
      S_AXI_ARREADY_OUT = st_r.ar_rdy;
      S_AXI_RVALID_OUT = st_r.rvalid;
      S_AXI_RDATA_OUT = st_r.rdata;
      S_AXI_RRESP_OUT = st_r.rresp;
   end

   // ==========================================
   // checks
   // an enabled magic match wakes when manageability is off
   wake_no_mng_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (PKT_VALID_IN && !st_r.ctrl[wfx_pkg::CTRL_MNGEN_BIT] &&
       (PKT_MAGIC_IN && st_r.ctrl[wfx_pkg::CTRL_MAGIC_BIT]))
      |=> WAKE_OUT)
      else $error("match lost with manageability off");

   // with exclusion clear an enabled directed match always wakes
   wake_excl_zero_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (PKT_VALID_IN && !st_r.ctrl[wfx_pkg::CTRL_EXCL_BIT] &&
       PKT_DIRECT_IN && st_r.ctrl[wfx_pkg::CTRL_DIRECT_BIT])
      |=> WAKE_OUT)
      else $error("match lost with exclusion clear");

   // a manageability packet never wakes while excluded
   excl_blocks_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (PKT_VALID_IN && PKT_MNG_IN && st_r.ctrl[wfx_pkg::CTRL_EXCL_BIT] &&
       st_r.ctrl[wfx_pkg::CTRL_MNGEN_BIT]) |=> !WAKE_OUT)
      else $error("excluded packet woke host");

   // an enabled broadcast magic match is logged but does not wake
   bcast_blocked_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (PKT_VALID_IN && PKT_MAGIC_IN && PKT_MNG_IN &&
       st_r.ctrl[wfx_pkg::CTRL_MAGIC_BIT] &&
       st_r.ctrl[wfx_pkg::CTRL_EXCL_BIT] &&
       st_r.ctrl[wfx_pkg::CTRL_MNGEN_BIT])
      |=> !WAKE_OUT && st_r.stat[wfx_pkg::ST_EXCL_BIT])
      else $error("broadcast magic woke host");

   // shared address, exclusion clear: mng unicast still wakes
   direct_mng_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (PKT_VALID_IN && PKT_DIRECT_IN && PKT_MNG_IN &&
       st_r.ctrl[wfx_pkg::CTRL_DIRECT_BIT] &&
       !st_r.ctrl[wfx_pkg::CTRL_EXCL_BIT]) |=> WAKE_OUT)
      else $error("mng unicast did not wake");

   // an excluded match leaves its status bit and no wake
   excl_status_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (PKT_VALID_IN && dec_excl)
      |=> !WAKE_OUT && st_r.stat[wfx_pkg::ST_EXCL_BIT])
      else $error("excluded match not logged");

   // every wake traces back to a strobed filter match
   wake_cause_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      WAKE_OUT |-> $past(PKT_VALID_IN) &&
      ($past(PKT_MAGIC_IN) || $past(PKT_DIRECT_IN)))
      else $error("wake without a match");

   // the wake pulse needs a packet strobe one cycle before
   wake_idle_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      !PKT_VALID_IN |=> !WAKE_OUT)
      else $error("wake without a packet strobe");

   // a wake leaves its sticky status bit behind
   wake_sticky_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      WAKE_OUT |-> st_r.stat[wfx_pkg::ST_WAKE_BIT])
      else $error("wake status bit not set");

   // the wake counter steps with every pulse
   wake_counts_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      WAKE_OUT |-> st_r.cnt == $past(st_r.cnt) + 16'h1)
      else $error("wake counter not advanced");

   // interrupt level follows unmasked status
   irq_level_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      ##1 (IRQ_OUT == |(st_r.stat & st_r.mask)))
      else $error("interrupt level mismatch");

   // a taken write address closes the channel until performed
   aw_block_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (S_AXI_AWVALID_IN && S_AXI_AWREADY_OUT) |=> !S_AXI_AWREADY_OUT)
      else $error("second write address accepted");

   // write response holds until the master takes it
   bresp_hold_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (S_AXI_BVALID_OUT && !S_AXI_BREADY_IN)
      |=> S_AXI_BVALID_OUT && $stable(S_AXI_BRESP_OUT))
      else $error("write response dropped early");

   // read data holds until the master takes it
   rdata_hold_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      (S_AXI_RVALID_OUT && !S_AXI_RREADY_IN)
      |=> S_AXI_RVALID_OUT && $stable(S_AXI_RDATA_OUT))
      else $error("read data dropped early");

   // no new read address is taken while data waits
   ar_block_a: assert property (
      @(posedge CLK_IN) disable iff (!RST_N_IN)
      S_AXI_RVALID_OUT |-> !S_AXI_ARREADY_OUT)
      else $error("read address taken while data waits");
endmodule
`default_nettype wire

// [verification/testbench.sv]
// testbench: self-checking bench for the wakeup exclusion block
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_fail++; \
   $display("wrong value at %0t: check failed", $time); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // signals
   logic clk = 1'b0, rst_n = 1'b0, go = 1'b0, pv, wake, irq, e;
   logic [2:0] hit = 3'h0, ph, h;
   logic awv = 1'b0, awr, wv = 1'b0, wr, bv, br = 1'b0;
   logic arv = 1'b0, arr, rv, rr = 1'b0;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic [31:0] wd = 32'h0, rd, d;
   logic [1:0] bresp, rresp, r;
   logic [3:0] c;
   logic [3:0] ws = 4'hf; // write strobes, held for a whole write
   int n_fail = 0, n_compared = 0, cyc = 0, n_wake = 0;
   always #20 clk = ~clk;
   wfx_rx_model i_wfx_rx_model (.clk_in(clk), .rst_n_in(rst_n),
      .go_in(go), .hit_in(hit), .valid_out(pv), .hit_out(ph));
   wfx_top i_wfx_top (.CLK_IN(clk), .RST_N_IN(rst_n), .PKT_VALID_IN(pv),
      .PKT_MAGIC_IN(ph[0]), .PKT_DIRECT_IN(ph[1]), .PKT_MNG_IN(ph[2]),
      .WAKE_OUT(wake), .IRQ_OUT(irq), .S_AXI_AWVALID_IN(awv),
      .S_AXI_AWREADY_OUT(awr), .S_AXI_AWADDR_IN(awa), .S_AXI_WVALID_IN(wv),
      .S_AXI_WREADY_OUT(wr), .S_AXI_WDATA_IN(wd), .S_AXI_WSTRB_IN(ws),
      .S_AXI_BVALID_OUT(bv), .S_AXI_BREADY_IN(br), .S_AXI_BRESP_OUT(bresp),
      .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arr),
      .S_AXI_ARADDR_IN(ara), .S_AXI_RVALID_OUT(rv), .S_AXI_RREADY_IN(rr),
      .S_AXI_RDATA_OUT(rd), .S_AXI_RRESP_OUT(rresp));
   // ==========================================
   // expected wake from control and hits
   function automatic logic exp_wake(input logic [3:0] cv,
                                     input logic [2:0] hv);
      return ((hv[0] & cv[2]) | (hv[1] & cv[3])) & ~(cv[1] & cv[0] & hv[2]);
   endfunction
   // axi4-lite write, address and data offered together
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= v;
      br <= 1'b1;
      do begin
         @(posedge clk);
         if (awr) awv <= 1'b0;
         if (wr) wv <= 1'b0;
      end while (!bv);
      br <= 1'b0;
      r = bresp;
      @(posedge clk);
   endtask
   // axi4-lite read
   task automatic rd_reg(input logic [7:0] a);
      arv <= 1'b1;
      ara <= a;
      rr <= 1'b1;
      do begin
         @(posedge clk);
         if (arr) arv <= 1'b0;
      end while (!rv);
      rr <= 1'b0;
      d = rd;
      r = rresp;
      @(posedge clk);
   endtask
   // one packet; returns one edge after the wake pulse stands
   task automatic pkt(input logic [2:0] hv);
      go <= 1'b1;
      hit <= hv;
      @(posedge clk);
      go <= 1'b0;
      hit <= ~hv;
      repeat (2) @(posedge clk);
   endtask
   task give_verdict;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // watchdog against a hung handshake
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         give_verdict;
      end
   end
   // ==========================================
   // main sequence
   initial begin
      void'($urandom(60461));
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(wfx_pkg::ADDR_CTRL);
      `CHK(d[3:0], wfx_pkg::CTRL_RST)
      rd_reg(wfx_pkg::ADDR_STAT);
      `CHK(d[1:0], wfx_pkg::STAT_RST)
      rd_reg(wfx_pkg::ADDR_MASK);
      `CHK(d[1:0], wfx_pkg::MASK_RST)
      rd_reg(8'h10);
      `CHK({r, d}, {wfx_pkg::RESP_SLVERR, 32'h0})
      wr_reg(8'h10, 32'h1);
      `CHK(r, wfx_pkg::RESP_SLVERR)
      // every control and hit mix, then random mixes
      for (int i = 0; i < 256; i++) begin
         c = (i < 128) ? 4'(i >> 3) : 4'($urandom);
         h = (i < 128) ? 3'(i) : 3'($urandom);
         wr_reg(wfx_pkg::ADDR_CTRL, {28'h0, c});
         `CHK(r, wfx_pkg::RESP_OKAY)
         pkt(h);
         e = exp_wake(c, h);
         n_wake += int'(e);
         `CHK(wake, e)
      end
      rd_reg(wfx_pkg::ADDR_CNT);
      `CHK(d[15:0], 16'(n_wake))
      // sticky status, mask and level interrupt
      wr_reg(wfx_pkg::ADDR_STAT, 32'h3);
      wr_reg(wfx_pkg::ADDR_MASK, 32'h0);
      wr_reg(wfx_pkg::ADDR_CTRL, 32'h7);
      pkt(3'h5);
      `CHK(wake, 1'b0)
      wr_reg(wfx_pkg::ADDR_CTRL, 32'h4);
      pkt(3'h1);
      rd_reg(wfx_pkg::ADDR_STAT);
      `CHK({irq, d[1:0]}, 3'h3)
      wr_reg(wfx_pkg::ADDR_MASK, 32'h1);
      `CHK(irq, 1'b1)
      wr_reg(wfx_pkg::ADDR_STAT, 32'h1);
      rd_reg(wfx_pkg::ADDR_STAT);
      `CHK({irq, d[1:0]}, 3'h2)
      // reset in mid-run restores the exclusion bit
      wr_reg(wfx_pkg::ADDR_CTRL, 32'h3);
      // a write without the low strobe must leave control alone
      ws <= 4'he;
      wr_reg(wfx_pkg::ADDR_CTRL, 32'hc);
      ws <= 4'hf;
      rd_reg(wfx_pkg::ADDR_CTRL);
      `CHK(d[3:0], 4'h3)
      rst_n <= 1'b0;
      @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd_reg(wfx_pkg::ADDR_CTRL);
      `CHK(d[3:0], wfx_pkg::CTRL_RST)
      give_verdict;
   end
endmodule
`default_nettype wire

// [verification/wfx_rx_model.sv]
// wfx_rx_model: receive path model issuing per-packet filter results
`default_nettype none
module wfx_rx_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // request from the bench
   input wire logic go_in,
   input wire logic [2:0] hit_in,
   // packet result toward the block
   output logic valid_out,
   output logic [2:0] hit_out
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // one-cycle strobe; hit lines scramble while not qualified
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         valid_out <= 1'b0;
         hit_out <= 3'h5;
      end else if (go_in) begin
         valid_out <= 1'b1;
         hit_out <= hit_in;
      end else begin
         valid_out <= 1'b0;
         hit_out <= ~hit_out; // stale lines must not leak into a wake
      end
   end
endmodule
`default_nettype wire
